/* pkg/bpm_pkg.sv */
// Shared constants and types for the bit-plane mirror formatter
// Functional notes
// - Accept 16, 20, 24 bit RGB, up to 120 Hz
// - Frame split equally into three colour slots
// - Plane duration proportional to two to bit; the code gives the closing plane of each slot one spare unit
// - Eight planes per slot, weights total 256
// - Store 24 planes, send one plane per transfer
// - Mirror on exactly where plane bit set
// - Interleave planes, slots and colour frames
// - DDR launch, 16-bit data plus control line
// - Output clocks may carry 1 percent spread
// - Normal or swapped full-bus channel order
package bpm_pkg;
  // Geometry of one stored frame and of the mirror channels
  localparam int unsigned PIX_PER_FRAME = 64;
  localparam int unsigned PIX_IDX_W     = 6;
  localparam int unsigned CHAN_BITS     = 16;
  localparam int unsigned COLOURS       = 3;
  localparam int unsigned PLANES        = 8;
  localparam int unsigned WEIGHT_TOTAL  = 256;
  // Input formats on the format select pins
  localparam logic [1:0]  FMT_16        = 2'h0;
  localparam logic [1:0]  FMT_20        = 2'h1;
  localparam logic [1:0]  FMT_24        = 2'h2;
  // Timing: colour slot at the highest frame rate
  localparam int unsigned MAX_FRAME_HZ  = 120;
  localparam int unsigned CLK_SYS_MHZ   = 250;
  localparam int unsigned SLOT_US_X100  = 278000;
  localparam int unsigned SLOT_CYCLES   = SLOT_US_X100 * CLK_SYS_MHZ / 100;
  localparam int unsigned UNIT_CYCLES   = SLOT_CYCLES / WEIGHT_TOTAL;
  localparam int unsigned HOLD_W        = 20;
  // Blanking that the source guarantees
  localparam int unsigned VBP_MIN_US    = 370;
  localparam int unsigned VFP_MIN_LINES = 1;
  localparam int unsigned HBP_MIN_PIX   = 10;
  localparam int unsigned HFP_MIN_PIX   = 0;
  localparam int unsigned HBLANK_MIN_PIX = 80;
  // Reset values
  localparam logic [1:0]  ROT_RESET     = 2'h0;
  // Plane sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_HOLD} bpm_seq_state_t;
endpackage

/* rtl/bpm_formatter.sv */
// Top: frame store, bit-plane sequencer with binary weighting, link hand-off
`timescale 1ns/100ps
module bpm_formatter #(
  parameter int unsigned UNIT_CYCLES = bpm_pkg::UNIT_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        link_clk_in,
  input  wire logic        frame_start_in,
  input  wire logic        pix_valid_in,
  input  wire logic [23:0] pix_data_in,
  input  wire logic [1:0]  pix_fmt_in,
  input  wire logic        bus_swap_in,
  output logic             frame_busy_out,
  output logic             frame_drop_out,
  output logic             mirror_clk_chan_a_out,
  output logic             mirror_clk_chan_b_out,
  output logic             mirror_ctrl_chan_a_out,
  output logic             mirror_ctrl_chan_b_out,
  output logic [15:0]      mirror_data_chan_a_rise_out,
  output logic [15:0]      mirror_data_chan_a_fall_out,
  output logic [15:0]      mirror_data_chan_b_rise_out,
  output logic [15:0]      mirror_data_chan_b_fall_out
);
  import bpm_pkg::*;

  typedef struct packed {
    logic [1:0][63:0][23:0] fb;
    logic                   wr_buf;
    logic [5:0]             wr_idx;
    logic [1:0]             ready;
    logic                   disp_buf;
    bpm_seq_state_t         state;
    logic [1:0]             slot;
    logic [2:0]             step;
    logic [1:0]             rot;
    logic [HOLD_W-1:0]      hold_cnt;
    logic                   req_tgl;
    logic                   ack_s1;
    logic                   ack_s2;
    logic [63:0]            plane;
    logic                   drop;
  } bpm_sys_state_t;

  bpm_sys_state_t st_reg;
  bpm_sys_state_t st_next;
  logic           ack_tgl;
  logic [23:0]    exp_pix;
  logic [5:0]     widx;
  logic [1:0]     colour;
  logic [2:0]     bitsel;
  logic [63:0]    plane_bits;
  logic [HOLD_W-1:0] hold_len;

  // Widen a 16 or 20 bit pixel to 8 bits per colour, red on top
  function automatic logic [23:0] expand(input logic [23:0] d, input logic [1:0] f);
    case (f)
      FMT_16:  expand = {d[15:11], 3'h0, d[10:5], 2'h0, d[4:0], 3'h0};
      FMT_20:  expand = {d[19:13], 1'h0, d[12:6], 1'h0, d[5:0], 2'h0};
      default: expand = d;
    endcase
  endfunction

  // Shuffled plane order so heavy and light bits alternate
  function automatic logic [2:0] plane_bit(input logic [2:0] s);
    case (s)
      3'h0:    plane_bit = 3'h7;
      3'h1:    plane_bit = 3'h0;
      3'h2:    plane_bit = 3'h5;
      3'h3:    plane_bit = 3'h2;
      3'h4:    plane_bit = 3'h6;
      3'h5:    plane_bit = 3'h1;
      3'h6:    plane_bit = 3'h4;
      default: plane_bit = 3'h3;
    endcase
  endfunction

  // Weight units of a slot step; the closing plane carries the spare unit so a slot totals 256
  function automatic logic [8:0] plane_units(input logic [2:0] s);
    plane_units = (9'h1 << plane_bit(s)) + ((s == 3'(PLANES - 1)) ? 9'h1 : 9'h0);
  endfunction

  // Colour of a slot, rotated from frame to frame
  function automatic logic [1:0] slot_colour(input logic [1:0] r, input logic [1:0] s);
    logic [2:0] sum;
    sum = {1'b0, r} + {1'b0, s};
    slot_colour = (sum >= 3'h3) ? 2'(sum - 3'h3) : sum[1:0];
  endfunction

  assign exp_pix  = expand(pix_data_in, pix_fmt_in);
  assign widx     = frame_start_in ? 6'h0 : st_reg.wr_idx;
  assign colour   = slot_colour(st_reg.rot, st_reg.slot);
  assign bitsel   = plane_bit(st_reg.step);
  assign hold_len = HOLD_W'(UNIT_CYCLES * plane_units(st_reg.step));

  // Gather one bit of every stored pixel into a plane
  always_comb begin
    for (int p = 0; p < PIX_PER_FRAME; p++) begin
      plane_bits[p] = st_reg.fb[st_reg.disp_buf][p][5'(({3'h0, 2'h2 - colour} << 3) + bitsel)];
    end
  end

  // Frame writer and plane sequencer
  always_comb begin
    st_next        = st_reg;
    st_next.ack_s1 = ack_tgl;
    st_next.ack_s2 = st_reg.ack_s1;
    st_next.drop   = 1'b0;
    // Writer fills the free buffer; a pixel that finds it still shown is dropped
    if (frame_start_in) begin
      st_next.wr_idx = 6'h0;
    end
    if (pix_valid_in) begin
      if (st_reg.ready[st_reg.wr_buf]) begin
        st_next.drop = 1'b1;
      end else begin
        st_next.fb[st_reg.wr_buf][widx] = exp_pix;
        if (widx == 6'(PIX_PER_FRAME - 1)) begin
          st_next.ready[st_reg.wr_buf] = 1'b1;
          st_next.wr_buf               = ~st_reg.wr_buf;
        end
      end
      st_next.wr_idx = 6'(widx + 6'h1);
    end
    case (st_reg.state)
      ST_IDLE: begin
        if (st_reg.ready[st_reg.disp_buf]) begin
          st_next.slot  = 2'h0;
          st_next.step  = 3'h0;
          st_next.state = ST_SEND;
        end
      end
      ST_SEND: begin
        st_next.plane    = plane_bits;
        st_next.req_tgl  = ~st_reg.req_tgl;
        st_next.hold_cnt = hold_len;
        st_next.state    = ST_HOLD;
      end
      ST_HOLD: begin
        if (st_reg.hold_cnt != '0) begin
          st_next.hold_cnt = st_reg.hold_cnt - 1'b1;
        end else if (st_reg.ack_s2 == st_reg.req_tgl) begin
          st_next.state = ST_SEND;
          st_next.step  = st_reg.step + 3'h1;
          if (st_reg.step == 3'(PLANES - 1)) begin
            st_next.slot = st_reg.slot + 2'h1;
            if (st_reg.slot == 2'(COLOURS - 1)) begin
              st_next.state                  = ST_IDLE;
              st_next.ready[st_reg.disp_buf] = 1'b0;
              st_next.disp_buf               = ~st_reg.disp_buf;
              st_next.slot                   = 2'h0;
              st_next.rot = (st_reg.rot == 2'h2) ? 2'h0 : st_reg.rot + 2'h1;
            end
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end

  // Whole sequencer state registered at once
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg     <= '0;
      st_reg.rot <= ROT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Link end on the mirror clock; plane held stable until acknowledged
  bpm_link_tx u_link (
    .link_clk_in                 (link_clk_in),
    .reset_in                    (reset_in),
    .bus_swap_in                 (bus_swap_in),
    .plane_req_tgl_in            (st_reg.req_tgl),
    .plane_data_in               (st_reg.plane),
    .plane_ack_tgl_out           (ack_tgl),
    .mirror_ctrl_chan_a_out      (mirror_ctrl_chan_a_out),
    .mirror_ctrl_chan_b_out      (mirror_ctrl_chan_b_out),
    .mirror_data_chan_a_rise_out (mirror_data_chan_a_rise_out),
    .mirror_data_chan_a_fall_out (mirror_data_chan_a_fall_out),
    .mirror_data_chan_b_rise_out (mirror_data_chan_b_rise_out),
    .mirror_data_chan_b_fall_out (mirror_data_chan_b_fall_out)
  );

  // Each channel forwards the link clock for DDR capture
  assign mirror_clk_chan_a_out = link_clk_in;
  assign mirror_clk_chan_b_out = link_clk_in;
  assign frame_busy_out        = st_reg.state != ST_IDLE;
  assign frame_drop_out        = st_reg.drop;

  // Weight accumulator over one colour slot, read only by checks
  logic [8:0] unit_acc;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      unit_acc <= 9'h0;
    end else if (st_reg.state == ST_SEND) begin
      unit_acc <= ((st_reg.step == 3'h0) ? 9'h0 : unit_acc) + plane_units(st_reg.step);
    end
  end

  sequence s_plane_sent;
    st_reg.state == ST_SEND ##1 st_reg.state == ST_HOLD;
  endsequence

  a_fmt_expand: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (pix_valid_in && !st_reg.ready[st_reg.wr_buf])
      |=> st_reg.fb[$past(st_reg.wr_buf)][$past(widx)] == $past(exp_pix))
    else $error("pixel not stored in widened form");
  a_slot_split: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $changed(st_reg.slot) && st_reg.state != ST_IDLE |-> $past(st_reg.step) == 3'h7)
    else $error("colour slot changed before eight planes");
  a_plane_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    s_plane_sent |-> st_reg.hold_cnt == HOLD_W'(UNIT_CYCLES << plane_bit(st_reg.step))
      + ((st_reg.step == 3'h7) ? HOLD_W'(UNIT_CYCLES) : HOLD_W'(0)))
    else $error("plane hold not weighted by its bit");
  a_slot_units: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (st_reg.state == ST_HOLD && st_reg.step == 3'h7) |-> unit_acc == 9'h100)
    else $error("slot weights do not total 256");
  a_req_held: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (st_reg.req_tgl != st_reg.ack_s2 && st_reg.state == ST_HOLD) |=> $stable(st_reg.plane))
    else $error("plane changed while transfer pending");
  a_plane_bits: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st_reg.state == ST_SEND |=> st_reg.plane == $past(plane_bits))
    else $error("sent plane differs from stored pixel bits");
  a_colour_order: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (st_reg.state == ST_IDLE ##1 st_reg.state == ST_SEND) |-> colour == st_reg.rot)
    else $error("frame does not start with rotated colour");
endmodule // bpm_formatter

/* rtl/bpm_link_tx.sv */
// Mirror-clock side: plane capture, channel split, swap and DDR halves
`timescale 1ns/100ps
module bpm_link_tx (
  input  wire logic        link_clk_in,
  input  wire logic        reset_in,
  input  wire logic        bus_swap_in,
  input  wire logic        plane_req_tgl_in,
  input  wire logic [63:0] plane_data_in,
  output logic             plane_ack_tgl_out,
  output logic             mirror_ctrl_chan_a_out,
  output logic             mirror_ctrl_chan_b_out,
  output logic [15:0]      mirror_data_chan_a_rise_out,
  output logic [15:0]      mirror_data_chan_a_fall_out,
  output logic [15:0]      mirror_data_chan_b_rise_out,
  output logic [15:0]      mirror_data_chan_b_fall_out
);
  import bpm_pkg::*;

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        ack_tgl;
    logic        swap_s1;
    logic        swap_s2;
    logic        ctrl_a;
    logic        ctrl_b;
    logic [31:0] data_a;
    logic [31:0] data_b;
  } bpm_link_state_t;

  bpm_link_state_t st_reg;
  bpm_link_state_t st_next;
  logic            rst_s1_reg;
  logic            rst_s2_reg;
  logic            new_plane;

  // Local reset: asserts at once, releases on the link clock
  always_ff @(posedge link_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
    end else begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign new_plane = st_reg.req_s2 != st_reg.ack_tgl;

  // Capture a plane, split it over both channels, pulse control
  always_comb begin
    st_next         = st_reg;
    st_next.req_s1  = plane_req_tgl_in;
    st_next.req_s2  = st_reg.req_s1;
    st_next.swap_s1 = bus_swap_in;
    st_next.swap_s2 = st_reg.swap_s1;
    st_next.ctrl_a  = 1'b0;
    st_next.ctrl_b  = 1'b0;
    if (new_plane) begin
      st_next.ack_tgl = st_reg.req_s2;
      st_next.ctrl_a  = 1'b1;
      st_next.ctrl_b  = 1'b1;
      if (st_reg.swap_s2) begin
        st_next.data_a = plane_data_in[63:32];
        st_next.data_b = plane_data_in[31:0];
      end else begin
        st_next.data_a = plane_data_in[31:0];
        st_next.data_b = plane_data_in[63:32];
      end
    end
  end

  // Logic is fully synchronous to the link clock, so a spread clock is harmless
  always_ff @(posedge link_clk_in or posedge rst_s2_reg) begin
    if (rst_s2_reg) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Low half goes out on the rising edge, high half on the falling edge
  assign mirror_data_chan_a_rise_out = st_reg.data_a[15:0];
  assign mirror_data_chan_a_fall_out = st_reg.data_a[31:16];
  assign mirror_data_chan_b_rise_out = st_reg.data_b[15:0];
  assign mirror_data_chan_b_fall_out = st_reg.data_b[31:16];
  assign mirror_ctrl_chan_a_out      = st_reg.ctrl_a;
  assign mirror_ctrl_chan_b_out      = st_reg.ctrl_b;
  assign plane_ack_tgl_out           = st_reg.ack_tgl;

  a_ddr_load: assert property (@(posedge link_clk_in) disable iff (rst_s2_reg)
    (new_plane && !st_reg.swap_s2) |=> (st_reg.data_a == $past(plane_data_in[31:0]))
      && st_reg.ctrl_a)
    else $error("channel A did not load the low plane half");
  a_swap_route: assert property (@(posedge link_clk_in) disable iff (rst_s2_reg)
    (new_plane && st_reg.swap_s2) |=> st_reg.data_b == $past(plane_data_in[31:0]))
    else $error("swapped order did not route low half to channel B");
  a_ctrl_single: assert property (@(posedge link_clk_in) disable iff (rst_s2_reg)
    st_reg.ctrl_a |=> !st_reg.ctrl_a && (st_reg.ctrl_b == 1'b0))
    else $error("control pulse longer than one link cycle");
  a_ack_follow: assert property (@(posedge link_clk_in) disable iff (rst_s2_reg)
    new_plane |=> (st_reg.ack_tgl == $past(st_reg.req_s2)) ##1 !new_plane)
    else $error("plane request not acknowledged");
endmodule // bpm_link_tx

/* verif/bpm_mirror_model.sv */
// Behavioural mirror array that latches each plane from the two DDR channels
`timescale 1ns/100ps
module bpm_mirror_model (
  input  wire logic        mirror_clk_chan_a_in,
  input  wire logic        mirror_clk_chan_b_in,
  input  wire logic        mirror_ctrl_chan_a_in,
  input  wire logic        mirror_ctrl_chan_b_in,
  input  wire logic [15:0] mirror_data_chan_a_rise_in,
  input  wire logic [15:0] mirror_data_chan_a_fall_in,
  input  wire logic [15:0] mirror_data_chan_b_rise_in,
  input  wire logic [15:0] mirror_data_chan_b_fall_in
);
  logic [63:0] plane_q[$];
  logic [1:0]  ctrl_b_q[$];
  realtime     time_q[$];

  // Sample mid-cycle, so words launched at the rising edge have settled
  always @(negedge mirror_clk_chan_a_in) begin
    if (mirror_ctrl_chan_a_in === 1'b1) begin
      plane_q.push_back({mirror_data_chan_b_fall_in, mirror_data_chan_b_rise_in,
                         mirror_data_chan_a_fall_in, mirror_data_chan_a_rise_in});
      // Channel B clock must be low with A's, and its control high in step
      ctrl_b_q.push_back({mirror_clk_chan_b_in, mirror_ctrl_chan_b_in});
      time_q.push_back($realtime);
    end
  end
endmodule // bpm_mirror_model

/* verif/test_bitplane_pwm_mirror_formatter.sv */
// Self-checking bench: frames in three formats, plane order, weights and swap
`timescale 1ns/100ps
module test_bitplane_pwm_mirror_formatter;
  import bpm_pkg::*;
  localparam int unsigned UNIT   = 16;
  localparam int unsigned SLACK  = 64;
  localparam int unsigned HBLANK = 80;
  localparam int unsigned VBLANK = 400;
  // One link period in system cycles: the spread in when a plane lands at the mirrors
  localparam real         LINK_SYS = 7.5;
  logic        clk_sys_in, reset_in, link_clk_in, frame_start_in, pix_valid_in;
  logic        bus_swap_in, frame_busy_out, frame_drop_out;
  logic        mirror_clk_chan_a_out, mirror_clk_chan_b_out;
  logic        mirror_ctrl_chan_a_out, mirror_ctrl_chan_b_out;
  logic [23:0] pix_data_in;
  logic [1:0]  pix_fmt_in;
  logic [15:0] a_rise, a_fall, b_rise, b_fall;
  int          num_errors, checked, drops;

  bpm_formatter #(.UNIT_CYCLES(UNIT)) u_bpm_formatter (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
    .frame_start_in(frame_start_in), .pix_valid_in(pix_valid_in),
    .pix_data_in(pix_data_in), .pix_fmt_in(pix_fmt_in), .bus_swap_in(bus_swap_in),
    .frame_busy_out(frame_busy_out), .frame_drop_out(frame_drop_out),
    .mirror_clk_chan_a_out(mirror_clk_chan_a_out), .mirror_clk_chan_b_out(mirror_clk_chan_b_out),
    .mirror_ctrl_chan_a_out(mirror_ctrl_chan_a_out),
    .mirror_ctrl_chan_b_out(mirror_ctrl_chan_b_out),
    .mirror_data_chan_a_rise_out(a_rise), .mirror_data_chan_a_fall_out(a_fall),
    .mirror_data_chan_b_rise_out(b_rise), .mirror_data_chan_b_fall_out(b_fall));

  bpm_mirror_model u_bpm_mirror_model (
    .mirror_clk_chan_a_in(mirror_clk_chan_a_out), .mirror_clk_chan_b_in(mirror_clk_chan_b_out),
    .mirror_ctrl_chan_a_in(mirror_ctrl_chan_a_out),
    .mirror_ctrl_chan_b_in(mirror_ctrl_chan_b_out),
    .mirror_data_chan_a_rise_in(a_rise), .mirror_data_chan_a_fall_in(a_fall),
    .mirror_data_chan_b_rise_in(b_rise), .mirror_data_chan_b_fall_in(b_fall));

  // System clock, 4 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Link clock near 30 ns, wobbling slightly like a spread source
  initial begin
    link_clk_in = 1'b0;
    #1.3;
    forever begin
      #15 link_clk_in = ~link_clk_in;
      #14.9 link_clk_in = ~link_clk_in;
    end
  end

  // Count discarded pixels; none are expected in this traffic
  always @(negedge clk_sys_in) begin
    if (frame_drop_out === 1'b1) drops++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [23:0] pix_val(input int p, input int f);
    return 24'((p * 24'h1d3b57) ^ (f * 24'h9e3779) ^ 24'h5a3c96);
  endfunction

  // Widened 8-bit colour c (0 red, 1 green, 2 blue) of one pixel
  function automatic logic [7:0] colour_of(input logic [1:0] fmt, input logic [23:0] px,
                                           input int c);
    logic [23:0] w;
    case (fmt)
      FMT_16: w = {px[15:11], 3'h0, px[10:5], 2'h0, px[4:0], 3'h0};
      FMT_20: w = {px[19:13], 1'h0, px[12:6], 1'h0, px[5:0], 2'h0};
      default: w = px;
    endcase
    return w[23 - 8 * c -: 8];
  endfunction

  // One frame of 8 lines of 8 pixels with source blanking
  task automatic send_frame(input logic [1:0] fmt, input int f);
    @(negedge clk_sys_in);
    pix_fmt_in = fmt;
    repeat (VBLANK) @(negedge clk_sys_in);
    for (int p = 0; p < 64; p++) begin
      @(negedge clk_sys_in);
      frame_start_in = (p == 0);
      pix_valid_in = 1'b1;
      pix_data_in = pix_val(p, f);
      if (p % 8 == 7) begin
        @(negedge clk_sys_in);
        frame_start_in = 1'b0;
        pix_valid_in = 1'b0;
        repeat (HBLANK - 1) @(negedge clk_sys_in);
      end
    end
  endtask

  // Wait for 24 planes, then judge content, order, channel split and hold
  task automatic check_frame(input logic [1:0] fmt, input logic swap, input int rot,
                             input int f);
    int          bits[8] = '{7, 0, 5, 2, 6, 1, 4, 3};
    logic [63:0] pl;
    logic [7:0]  cv;
    int          col, b, n, h;
    realtime     dt;
    n = 0;
    while (u_bpm_mirror_model.plane_q.size() < 24 && n < 20000) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      report_and_stop();
    end
    check({63'h0, frame_busy_out}, 64'h1);
    for (int k = 0; k < 24; k++) begin
      col = (rot + k / 8) % 3;
      b = bits[k % 8];
      for (int p = 0; p < 64; p++) begin
        cv = colour_of(fmt, pix_val(p, f), col);
        pl[p] = cv[b];
      end
      if (swap) pl = {pl[31:0], pl[63:32]};
      check(u_bpm_mirror_model.plane_q[k], pl);
      check({62'h0, u_bpm_mirror_model.ctrl_b_q[k]}, 64'h1);
      if (k < 23) begin
        // Closing plane of each slot carries one spare unit so the slot totals 256
        h = UNIT * ((1 << b) + ((k % 8 == 7) ? 1 : 0));
        dt = (u_bpm_mirror_model.time_q[k + 1] - u_bpm_mirror_model.time_q[k]) / 4.0;
        check({63'h0, dt > h + 2 - LINK_SYS && dt <= h + SLACK}, 64'h1);
      end
    end
    u_bpm_mirror_model.plane_q.delete();
    u_bpm_mirror_model.ctrl_b_q.delete();
    u_bpm_mirror_model.time_q.delete();
  endtask

  task automatic scen_reset_idle;
    @(negedge clk_sys_in);
    check({60'h0, frame_busy_out, frame_drop_out, mirror_ctrl_chan_a_out,
           mirror_ctrl_chan_b_out}, 64'h0);
    check({b_fall, b_rise, a_fall, a_rise}, 64'h0);
    check({62'h0, mirror_clk_chan_a_out, mirror_clk_chan_b_out},
          {62'h0, link_clk_in, link_clk_in});
  endtask

  task automatic scen_frame_24_normal;
    @(negedge clk_sys_in);
    bus_swap_in = 1'b0;
    send_frame(FMT_24, 0);
    check_frame(FMT_24, 1'b0, 0, 0);
  endtask

  task automatic scen_frame_16_swapped;
    @(negedge clk_sys_in);
    bus_swap_in = 1'b1;
    send_frame(FMT_16, 1);
    check_frame(FMT_16, 1'b1, 1, 1);
  endtask

  task automatic scen_frame_20_normal;
    @(negedge clk_sys_in);
    bus_swap_in = 1'b0;
    send_frame(FMT_20, 2);
    check_frame(FMT_20, 1'b0, 2, 2);
    check(64'(drops), 64'h0);
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    drops = 0;
    reset_in = 1'b1;
    frame_start_in = 1'b0;
    pix_valid_in = 1'b0;
    pix_data_in = 24'h0;
    pix_fmt_in = FMT_24;
    bus_swap_in = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    scen_reset_idle();
    reset_in = 1'b0;
    scen_frame_24_normal();
    scen_frame_16_swapped();
    scen_frame_20_normal();
    report_and_stop();
  end
endmodule // test_bitplane_pwm_mirror_formatter
